// ### rtl/mrs_pkg.sv
// package: opcodes, field positions and reset values for the execute block
package mrs_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;
  localparam int PC_W = 11;
  localparam int INSTR_W = 12;
  // 12-bit opcode patterns and masks
  localparam logic [11:0] OP_NOP = 12'h000;
  localparam logic [11:0] OP_CFG = 12'h002;
  localparam logic [11:0] OP_SLEEP = 12'h003;
  localparam logic [11:0] MASK_FULL = 12'hfff;
  localparam logic [11:0] OP_ACC_TO_FILE = 12'h020;
  localparam logic [11:0] MASK_ACC_TO_FILE = 12'hfe0;
  localparam logic [11:0] OP_FILE_MOVE = 12'h200;
  localparam logic [11:0] OP_ROTATE_LEFT = 12'h340;
  localparam logic [11:0] MASK_FD = 12'hfc0;
  localparam logic [11:0] OP_RET_LIT = 12'h800;
  localparam logic [11:0] OP_LIT_TO_ACC = 12'hc00;
  localparam logic [11:0] MASK_LIT = 12'hf00;
  // field positions
  localparam int DEST_BIT = 5;
  localparam int MSB_BIT = 7;
  // reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'hff;
  localparam logic [7:0] WDT_CLR = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [10:0] PC_RST = 11'h000;
  localparam logic [10:0] PC_STEP = 11'h001;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_RET2 = 2'b01,
    ST_SLEEP = 2'b10
  } mrs_state_type;
endpackage

// ### rtl/mrs_exec.sv
// execute stage for move, literal, return, sleep and rotate instructions
// Notes on behaviour
// - acc_to_file_instr writes the accumulator into file register 0..31, flags kept.
// - file_move_instr sends the register to the accumulator if d is 0, else back to it.
// - file_move_instr sets the zero flag from the moved value.
// - literal_to_acc_instr loads the 8-bit literal into the accumulator, flags kept.
// - the configuration load copies the accumulator into the config register.
// - return_literal_instr loads the literal and takes the pc from stack_top_entry.
// - return_literal_instr takes two instruction cycles.
// - sleep clears the watchdog_counter and its prescaler.
// - sleep sets timeout_status and clears powerdown_status.
// - sleep puts the core asleep with the oscillator stopped.
// - rotate_left_carry_instr shifts left via carry to accumulator or register.
`timescale 1ns/10ps
`default_nettype none
module mrs_exec
  import mrs_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic instr_valid,
  input wire logic [INSTR_W-1:0] instr,
  input wire logic [DATA_W-1:0] file_rdata,
  input wire logic [PC_W-1:0] stack_top_entry,
  input wire logic wake,
  output logic instr_ready,
  output logic [ADDR_W-1:0] file_addr,
  output logic file_we,
  output logic [DATA_W-1:0] file_wdata,
  output logic [DATA_W-1:0] acc,
  output logic [DATA_W-1:0] cfg_reg,
  output logic [PC_W-1:0] pc,
  output logic zero_flag,
  output logic carry_flag,
  output logic timeout_status,
  output logic powerdown_status,
  output logic [DATA_W-1:0] watchdog_counter,
  output logic [DATA_W-1:0] wdt_prescaler,
  output logic stack_pop,
  output logic osc_run,
  output logic asleep
);
  function automatic logic op_is(input logic [11:0] i, input logic [11:0] op,
                                 input logic [11:0] m);
    op_is = (i & m) == op;
  endfunction

  mrs_state_type state_q, state_d;
  logic [7:0] acc_q, acc_d, cfg_q, cfg_d, wdt_q, wdt_d, pre_q, pre_d;
  logic [7:0] wdata_q, wdata_d;
  logic [10:0] pc_q, pc_d;
  logic [4:0] addr_q, addr_d;
  logic we_q, we_d, z_q, z_d, c_q, c_d, to_q, to_d, pd_q, pd_d;
  logic pop_q, pop_d;
  logic wake_s1_q, wake_s2_q;
  logic go, dest_f;
  logic [7:0] rot;

  assign instr_ready = (state_q == ST_RUN);
  assign go = instr_valid && instr_ready;
  assign dest_f = instr[DEST_BIT];
  assign rot = {file_rdata[MSB_BIT-1:0], c_q};

  // wake level synchroniser
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
    end else begin
      wake_s1_q <= wake;
      wake_s2_q <= wake_s1_q;
    end
  end

  // next-state decode
  always_comb begin
    state_d = state_q;
    acc_d = acc_q;
    cfg_d = cfg_q;
    wdt_d = wdt_q + BYTE_ONE;
    pre_d = pre_q;
    pc_d = pc_q;
    addr_d = instr[ADDR_W-1:0];
    we_d = 1'b0;
    wdata_d = wdata_q;
    z_d = z_q;
    c_d = c_q;
    to_d = to_q;
    pd_d = pd_q;
    pop_d = 1'b0;
    unique case (state_q)
      ST_RUN: begin
        if (go) begin
          pc_d = pc_q + PC_STEP;
          if (op_is(instr, OP_ACC_TO_FILE, MASK_ACC_TO_FILE)) begin
            we_d = 1'b1;
            wdata_d = acc_q;
          end else if (op_is(instr, OP_FILE_MOVE, MASK_FD)) begin
            z_d = (file_rdata == ACC_RST);
            if (dest_f) begin
              we_d = 1'b1;
              wdata_d = file_rdata;
            end else begin
              acc_d = file_rdata;
            end
          end else if (op_is(instr, OP_ROTATE_LEFT, MASK_FD)) begin
            c_d = file_rdata[MSB_BIT];
            if (dest_f) begin
              we_d = 1'b1;
              wdata_d = rot;
            end else begin
              acc_d = rot;
            end
          end else if (op_is(instr, OP_LIT_TO_ACC, MASK_LIT)) begin
            acc_d = instr[DATA_W-1:0];
          end else if (op_is(instr, OP_RET_LIT, MASK_LIT)) begin
            acc_d = instr[DATA_W-1:0];
            pc_d = stack_top_entry;
            pop_d = 1'b1;
            state_d = ST_RET2;
          end else if (op_is(instr, OP_CFG, MASK_FULL)) begin
            cfg_d = acc_q;
          end else if (op_is(instr, OP_SLEEP, MASK_FULL)) begin
            wdt_d = WDT_CLR;
            pre_d = WDT_CLR;
            to_d = 1'b1;
            pd_d = 1'b0;
            state_d = ST_SLEEP;
          end
        end
      end
      ST_RET2: state_d = ST_RUN;
      ST_SLEEP: begin
        wdt_d = wdt_q;
        if (wake_s2_q) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  // state registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_RUN;
      acc_q <= ACC_RST;
      cfg_q <= CFG_RST;
      wdt_q <= WDT_CLR;
      pre_q <= WDT_CLR;
      pc_q <= PC_RST;
      addr_q <= '0;
      we_q <= 1'b0;
      wdata_q <= ACC_RST;
      z_q <= 1'b0;
      c_q <= 1'b0;
      to_q <= 1'b1;
      pd_q <= 1'b1;
      pop_q <= 1'b0;
    end else begin
      state_q <= state_d;
      acc_q <= acc_d;
      cfg_q <= cfg_d;
      wdt_q <= wdt_d;
      pre_q <= pre_d;
      pc_q <= pc_d;
      addr_q <= addr_d;
      we_q <= we_d;
      wdata_q <= wdata_d;
      z_q <= z_d;
      c_q <= c_d;
      to_q <= to_d;
      pd_q <= pd_d;
      pop_q <= pop_d;
    end
  end

  // outputs
  assign file_addr = go ? instr[ADDR_W-1:0] : addr_q;
  assign file_we = we_q;
  assign file_wdata = wdata_q;
  assign acc = acc_q;
  assign cfg_reg = cfg_q;
  assign pc = pc_q;
  assign zero_flag = z_q;
  assign carry_flag = c_q;
  assign timeout_status = to_q;
  assign powerdown_status = pd_q;
  assign watchdog_counter = wdt_q;
  assign wdt_prescaler = pre_q;
  assign stack_pop = pop_q;
  assign asleep = (state_q == ST_SLEEP);
  assign osc_run = !asleep;

  a_acc_write: assert property (@(posedge clk) disable iff (!nrst)
    go && op_is(instr, OP_ACC_TO_FILE, MASK_ACC_TO_FILE) |=>
      file_we && file_wdata == $past(acc_q) && $stable(z_q))
    else $error("acc to file wrong");
  a_move_zero: assert property (@(posedge clk) disable iff (!nrst)
    go && op_is(instr, OP_FILE_MOVE, MASK_FD) |=>
      z_q == ($past(file_rdata) == ACC_RST))
    else $error("zero flag wrong");
  a_move_dest: assert property (@(posedge clk) disable iff (!nrst)
    go && op_is(instr, OP_FILE_MOVE, MASK_FD) && !dest_f |=>
      acc_q == $past(file_rdata) && !file_we)
    else $error("move dest wrong");
  a_lit_load: assert property (@(posedge clk) disable iff (!nrst)
    go && op_is(instr, OP_LIT_TO_ACC, MASK_LIT) |=>
      acc_q == $past(instr[7:0]) && $stable(c_q))
    else $error("literal load wrong");
  a_cfg_load: assert property (@(posedge clk) disable iff (!nrst)
    go && op_is(instr, OP_CFG, MASK_FULL) |=> cfg_q == $past(acc_q))
    else $error("config load wrong");
  sequence s_ret_busy;
    !instr_ready ##1 instr_ready;
  endsequence
  a_ret_two: assert property (@(posedge clk) disable iff (!nrst)
    go && op_is(instr, OP_RET_LIT, MASK_LIT) |=>
      pc_q == $past(stack_top_entry) ##0 s_ret_busy)
    else $error("return timing wrong");
  a_sleep_stat: assert property (@(posedge clk) disable iff (!nrst)
    go && op_is(instr, OP_SLEEP, MASK_FULL) |=>
      to_q && !pd_q && wdt_q == WDT_CLR && pre_q == WDT_CLR && !osc_run)
    else $error("sleep entry wrong");
  a_rot_carry: assert property (@(posedge clk) disable iff (!nrst)
    go && op_is(instr, OP_ROTATE_LEFT, MASK_FD) |=>
      c_q == $past(file_rdata[7]))
    else $error("rotate carry wrong");
endmodule
`default_nettype wire

// ### dv/testbench.sv
// self-checking bench for the move, literal, return, sleep and rotate block
`timescale 1ns/10ps
`default_nettype none
module testbench import mrs_pkg::*;;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic instr_valid = 1'b0;
  logic [INSTR_W-1:0] instr = 12'h000;
  logic [DATA_W-1:0] file_rdata = 8'h00;
  logic [PC_W-1:0] stack_top_entry = 11'h3c4;
  logic wake = 1'b0;
  logic instr_ready, file_we, zero_flag, carry_flag, timeout_status;
  logic powerdown_status, stack_pop, osc_run, asleep;
  logic [ADDR_W-1:0] file_addr;
  logic [DATA_W-1:0] file_wdata, acc, cfg_reg, watchdog_counter, wdt_prescaler;
  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] epc = 11'h000;
  int fails = 0;
  int compares = 0;
  mrs_exec mrs_exec_inst (.clk, .nrst, .instr_valid, .instr, .file_rdata,
    .stack_top_entry, .wake, .instr_ready, .file_addr, .file_we, .file_wdata,
    .acc, .cfg_reg, .pc, .zero_flag, .carry_flag, .timeout_status,
    .powerdown_status, .watchdog_counter, .wdt_prescaler, .stack_pop,
    .osc_run, .asleep);
  // 250 mhz clock
  always #2 clk = ~clk;
  task automatic chk(input logic [10:0] g, input logic [10:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one instruction taken at the next edge, results settled after it
  task automatic run(input logic [11:0] w, input logic [7:0] rd);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr <= w;
    file_rdata <= rd;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    epc = epc + 11'h001;
  endtask
  task automatic t_literal;
    run(12'hc5a, 8'h00);
    chk(acc, 8'h5a);
    run(12'hc00, 8'h00);
    chk(acc, 8'h00);
    chk(zero_flag, 1'b0);
    chk(pc, epc);
  endtask
  task automatic t_acc_file;
    run(12'hca5, 8'h00);
    run(12'h03f, 8'h00);
    chk(file_we, 1'b1);
    chk(file_wdata, 8'ha5);
    chk(file_addr, 5'h1f);
    chk(zero_flag, 1'b0);
  endtask
  task automatic t_file_move;
    run(12'h203, 8'h00);
    chk(acc, 8'h00);
    chk(file_we, 1'b0);
    chk(zero_flag, 1'b1);
    run(12'h224, 8'h80);
    chk(file_we, 1'b1);
    chk(file_wdata, 8'h80);
    chk(acc, 8'h00);
    chk(zero_flag, 1'b0);
  endtask
  task automatic t_cfg;
    run(12'h203, 8'h00);
    run(12'hc3c, 8'h00);
    run(12'h002, 8'h00);
    chk(cfg_reg, 8'h3c);
    chk(zero_flag, 1'b1);
  endtask
  task automatic t_rotate;
    run(12'h345, 8'h81);
    chk(acc, 8'h02);
    chk(carry_flag, 1'b1);
    run(12'h365, 8'h40);
    chk(file_we, 1'b1);
    chk(file_wdata, 8'h81);
    chk(carry_flag, 1'b0);
  endtask
  task automatic t_nop;
    run(12'h000, 8'hff);
    chk(acc, 8'h02);
    chk(file_we, 1'b0);
    chk(pc, epc);
  endtask
  task automatic t_return;
    run(12'h8a5, 8'h00);
    epc = 11'h3c4;
    chk(acc, 8'ha5);
    chk(pc, epc);
    chk(stack_pop, 1'b1);
    chk(instr_ready, 1'b0);
    @(posedge clk);
    #1;
    chk(instr_ready, 1'b1);
  endtask
  task automatic t_sleep;
    int n;
    run(12'h003, 8'h00);
    chk(asleep, 1'b1);
    chk(osc_run, 1'b0);
    chk(timeout_status, 1'b1);
    chk(powerdown_status, 1'b0);
    chk(watchdog_counter, 8'h00);
    chk(wdt_prescaler, 8'h00);
    repeat (3) @(posedge clk);
    wake <= 1'b1;
    for (n = 0; n < 8 && instr_ready !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    wake <= 1'b0;
    if (n == 8) begin
      fails++;
      $display("mismatch at %0t: no wake from sleep", $time);
    end else begin
      chk(osc_run, 1'b1);
    end
  endtask
  task automatic final_report;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // reset for two cycles, then the scenarios
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_literal();
    t_acc_file();
    t_file_move();
    t_cfg();
    t_rotate();
    t_nop();
    t_return();
    t_sleep();
    final_report();
  end
endmodule
`default_nettype wire
